// ### rtl/spio_port.sv
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "spio_defines.svh"
`default_nettype none

module spio_port
    import spio_pkg::*;
#(
    parameter int          WIDTH     = 16,
    parameter logic [15:0] IMPL_MASK = 16'hFFFF,
    parameter int          NFUNC     = 64,
    // Port bits behind the four remappable pins 42, 43, 54, 55.
    parameter int          REMAP_BIT_42 = 0,
    parameter int          REMAP_BIT_43 = 1,
    parameter int          REMAP_BIT_54 = 2,
    parameter int          REMAP_BIT_55 = 3
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // AXI4-Lite write address
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Fixed-function peripherals per pin
    input  wire logic [WIDTH-1:0]  periph_enable,
    input  wire logic [WIDTH-1:0]  periph_driving,
    input  wire logic [WIDTH-1:0]  periph_data,
    output logic [WIDTH-1:0]       periph_in,
    // Remappable output functions
    input  wire logic [NFUNC-1:0]  func_data,
    input  wire logic [NFUNC-1:0]  func_driving,
    // Pads
    input  wire logic [WIDTH-1:0]  pad_in,
    output logic [WIDTH-1:0]       pad_out,
    output logic [WIDTH-1:0]       pad_oe
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] direction_reg;
    logic [WIDTH-1:0] output_latch_reg;
    logic [WIDTH-1:0] pin_level_reg;
    logic [15:0]      output_pin_select_4;
    logic [15:0]      output_pin_select_5;
    logic [WIDTH-1:0] impl;
    logic [WIDTH-1:0] next_latch;
    logic [15:0]      dir_merged;
    logic [15:0]      latch_merged;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             do_write;
    logic             wr_hit;
    spio_rd_state_t   rd_state;
    logic [31:0]      next_rdata;
    logic             rd_hit;

    assign impl = IMPL_MASK[WIDTH-1:0];

    // Byte-lane merge of a 16-bit register from a 32-bit write.
    function automatic logic [15:0] spio_merge(input logic [15:0] old_v,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        spio_merge = old_v;
        if (strb[0]) begin
            spio_merge[7:0] = data[7:0];
        end
        if (strb[1]) begin
            spio_merge[15:8] = data[15:8];
        end
    endfunction : spio_merge

    function automatic logic spio_known(input logic [7:0] a);
        spio_known = (a == `SPIO_OFF_DIRECTION) || (a == `SPIO_OFF_LATCH) ||
                     (a == `SPIO_OFF_PIN_LEVEL) || (a == `SPIO_OFF_SELECT_4) ||
                     (a == `SPIO_OFF_SELECT_5);
    endfunction : spio_known

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data are captured independently, so either may arrive first.
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    assign wr_hit        = spio_known(aw_addr);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SPIO_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SPIO_RESP_OKAY : `SPIO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------------
    assign dir_merged   = spio_merge(16'(direction_reg), w_data, w_strb);
    assign latch_merged = spio_merge(16'(output_latch_reg), w_data, w_strb);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_reg <= '1;
        end else if (do_write && aw_addr == `SPIO_OFF_DIRECTION) begin
            direction_reg <= dir_merged[WIDTH-1:0] | ~impl;
        end
    end

    // Both the latch and the pin level offsets land in the latch.
    always_comb begin
        next_latch = output_latch_reg;
        if (do_write && (aw_addr == `SPIO_OFF_LATCH ||
                         aw_addr == `SPIO_OFF_PIN_LEVEL)) begin
            next_latch = latch_merged[WIDTH-1:0] & impl;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_latch_reg <= '0;
        end else begin
            output_latch_reg <= next_latch;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_level_reg <= '0;
        end else begin
            pin_level_reg <= pad_in & impl;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_pin_select_4 <= `SPIO_SELECT_RESET;
            output_pin_select_5 <= `SPIO_SELECT_RESET;
        end else if (do_write && aw_addr == `SPIO_OFF_SELECT_4) begin
            output_pin_select_4 <= spio_merge(output_pin_select_4, w_data, w_strb)
                                   & `SPIO_SEL_MASK;
        end else if (do_write && aw_addr == `SPIO_OFF_SELECT_5) begin
            output_pin_select_5 <= spio_merge(output_pin_select_5, w_data, w_strb)
                                   & `SPIO_SEL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = (rd_state == SPIO_RD_IDLE);
    assign rd_hit        = spio_known({s_axi_araddr[7:2], 2'b00});

    always_comb begin
        next_rdata = 32'h0000_0000;
        case ({s_axi_araddr[7:2], 2'b00})
            `SPIO_OFF_DIRECTION: next_rdata[WIDTH-1:0] = direction_reg & impl;
            `SPIO_OFF_LATCH:     next_rdata[WIDTH-1:0] = output_latch_reg;
            `SPIO_OFF_PIN_LEVEL: next_rdata[WIDTH-1:0] = pin_level_reg;
            `SPIO_OFF_SELECT_4:  next_rdata[15:0]      = output_pin_select_4;
            `SPIO_OFF_SELECT_5:  next_rdata[15:0]      = output_pin_select_5;
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state    <= SPIO_RD_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SPIO_RESP_OKAY;
        end else begin
            case (rd_state)
                SPIO_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state    <= SPIO_RD_RESP;
                        s_axi_rdata <= next_rdata;
                        s_axi_rresp <= rd_hit ? `SPIO_RESP_OKAY : `SPIO_RESP_SLVERR;
                    end
                end
                SPIO_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= SPIO_RD_IDLE;
                    end
                end
                default: rd_state <= SPIO_RD_IDLE;
            endcase
        end
    end

    assign s_axi_rvalid = (rd_state == SPIO_RD_RESP);

    // ------------------------------------------------------------------
    // Remappable output selection
    // ------------------------------------------------------------------
    // Remapped pins behave like a peripheral on the pin; a selector of zero
    // connects nothing and the fixed peripheral inputs then apply.
    logic [WIDTH-1:0] remap_sel;
    logic [WIDTH-1:0] remap_drv;
    logic [WIDTH-1:0] remap_dat;
    logic [5:0]       remap_pin_42_function;
    logic [5:0]       remap_pin_43_function;
    logic [5:0]       remap_pin_54_function;
    logic [5:0]       remap_pin_55_function;

    assign remap_pin_42_function = output_pin_select_4[`SPIO_SEL_LO_LSB +: `SPIO_SEL_W];
    assign remap_pin_43_function = output_pin_select_4[`SPIO_SEL_HI_LSB +: `SPIO_SEL_W];
    assign remap_pin_54_function = output_pin_select_5[`SPIO_SEL_LO_LSB +: `SPIO_SEL_W];
    assign remap_pin_55_function = output_pin_select_5[`SPIO_SEL_HI_LSB +: `SPIO_SEL_W];

    function automatic logic [5:0] spio_fn_for(input int bit_i,
                                               input logic [5:0] f42, input logic [5:0] f43,
                                               input logic [5:0] f54, input logic [5:0] f55);
        spio_fn_for = `SPIO_FUNC_NONE;
        if (bit_i == REMAP_BIT_42) spio_fn_for = f42;
        if (bit_i == REMAP_BIT_43) spio_fn_for = f43;
        if (bit_i == REMAP_BIT_54) spio_fn_for = f54;
        if (bit_i == REMAP_BIT_55) spio_fn_for = f55;
    endfunction : spio_fn_for

    // ------------------------------------------------------------------
    // Per-pin ownership
    // ------------------------------------------------------------------
    // A pin whose peripherals only listen simply never raises periph_driving.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            logic [5:0] fn;
            logic       own_en;
            logic       own_drv;
            logic       own_dat;
            logic       mux_out;
            logic       mux_oe;
            logic       mux_dat;
            assign fn           = spio_fn_for(gi, remap_pin_42_function, remap_pin_43_function,
                                              remap_pin_54_function, remap_pin_55_function);
            assign remap_sel[gi] = (fn != `SPIO_FUNC_NONE);
            assign remap_drv[gi] = remap_sel[gi] & func_driving[fn];
            assign remap_dat[gi] = func_data[fn];
            assign own_en  = remap_sel[gi] | periph_enable[gi];
            assign own_drv = remap_sel[gi] ? remap_drv[gi] : periph_driving[gi];
            assign own_dat = remap_sel[gi] ? remap_dat[gi] : periph_data[gi];

            spio_pin_mux u_mux (
                .port_data      (output_latch_reg[gi]),
                .port_out_en    (~direction_reg[gi]),
                .periph_enable  (own_en),
                .periph_driving (own_drv),
                .periph_data    (own_dat),
                .pin_in         (pad_in[gi]),
                .periph_in      (mux_out),
                .pad_out        (mux_dat),
                .pad_oe         (mux_oe)
            );
            // Unimplemented bits are held off entirely.
            assign periph_in[gi] = mux_out & impl[gi];
            assign pad_oe[gi]    = mux_oe & impl[gi];
            assign pad_out[gi]   = mux_dat & impl[gi];
        end
    endgenerate
endmodule : spio_port

`default_nettype wire

// ### rtl/spio_defines.svh
`ifndef SPIO_DEFINES_SVH
`define SPIO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SPIO_OFF_DIRECTION   8'h00
`define SPIO_OFF_LATCH       8'h04
`define SPIO_OFF_PIN_LEVEL   8'h08
`define SPIO_OFF_SELECT_4    8'h0C
`define SPIO_OFF_SELECT_5    8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SPIO_SEL_HI_LSB      8
`define SPIO_SEL_LO_LSB      0
`define SPIO_SEL_W           6
`define SPIO_SEL_MASK        16'h3F3F
`define SPIO_SELECT_RESET    16'h0000
`define SPIO_FUNC_NONE       6'h00

// ----------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------
`define SPIO_RESP_OKAY       2'h0
`define SPIO_RESP_SLVERR     2'h2

`endif

// ### rtl/spio_pkg.sv
`default_nettype none

package spio_pkg;
    typedef enum logic [1:0] {
        SPIO_RD_IDLE,
        SPIO_RD_RESP
    } spio_rd_state_t;
endpackage : spio_pkg

`default_nettype wire

// ### rtl/spio_pin_mux.sv
`include "spio_defines.svh"
`default_nettype none

// ----------------------------------------------------------------------
// Output ownership for one pin
// ----------------------------------------------------------------------
module spio_pin_mux (
    // Port side
    input  wire logic       port_data,
    input  wire logic       port_out_en,
    // Peripheral side
    input  wire logic       periph_enable,
    input  wire logic       periph_driving,
    input  wire logic       periph_data,
    input  wire logic       pin_in,
    output logic            periph_in,
    // Pad side
    output logic            pad_out,
    output logic            pad_oe
);
    logic periph_owns;

    // An enabled peripheral that is idle leaves the pin to the port.
    assign periph_owns = periph_enable & periph_driving;
    assign pad_out     = periph_owns ? periph_data : port_data;
    assign pad_oe      = periph_owns ? 1'b1 : port_out_en;
    // The peripheral only ever sees the pad as it stands when the port is not driving it.
    assign periph_in   = (port_out_en & ~periph_owns) ? 1'b0 : pin_in;
endmodule : spio_pin_mux

`default_nettype wire

// ### sim/spio_far_model.sv
`default_nettype none

// ----------------------------------------------------------------------
// Board side of the pads
// ----------------------------------------------------------------------
module spio_far_model (
    // Device pads
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    // Board level on pins the device leaves alone
    input  wire logic [15:0] ext_level,
    output logic      [15:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // An undriven pin follows the board level, so no stale device value lingers.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : spio_far_model

`default_nettype wire

// ### sim/spio_port_checker.sv
`default_nettype none

module spio_port_checker #(
    parameter int          WIDTH     = 16,
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    // Clock and reset
    input wire logic             ref_clk,
    input wire logic             rst_n,
    // Bus handshakes
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    // Pins
    input wire logic [WIDTH-1:0] periph_enable,
    input wire logic [WIDTH-1:0] periph_driving,
    input wire logic [WIDTH-1:0] periph_data,
    input wire logic [WIDTH-1:0] periph_in,
    input wire logic [WIDTH-1:0] pad_out,
    input wire logic [WIDTH-1:0] pad_oe
);
    // Remappable bits 3:0 are left out: their owner depends on a selector.
    localparam logic [15:0] FIXED = 16'h7FF0;
    logic [WIDTH-1:0] owned;
    assign owned = periph_enable & periph_driving;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Address and data are held for one cycle before the response rises.
    a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response not raised");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data not raised");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_periph_owns: assert property (((pad_oe & owned & FIXED) == (owned & FIXED))
        && (((pad_out ^ periph_data) & owned & FIXED) == 16'h0000))
        else $error("peripheral lost pin ownership");
    a_no_loop: assert property ((periph_in & pad_oe & ~owned & FIXED) == 16'h0000)
        else $error("port output looped into peripheral");
    // A driving peripheral on a missing bit must not reach the pad either.
    a_unimpl_off: assert property ((pad_oe & ~IMPL_MASK) == 16'h0000)
        else $error("unimplemented bit drives pad");
    a_reset_input: assert property ($rose(rst_n) |-> (pad_oe & ~owned) == 16'h0000)
        else $error("pin driven after reset");
endmodule : spio_port_checker

bind spio_port spio_port_checker #(.WIDTH(WIDTH), .IMPL_MASK(IMPL_MASK)) u_spio_port_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_enable(periph_enable),
    .periph_driving(periph_driving), .periph_data(periph_data), .periph_in(periph_in),
    .pad_out(pad_out), .pad_oe(pad_oe));

`default_nettype wire

// ### sim/tb_top.sv
`include "spio_defines.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] IMPL = 16'h7FFF;
    logic        ref_clk, awready, wready, bvalid, arready, rvalid;
    logic        rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [15:0] pen = 16'h0, pdrv = 16'h0, pdat = 16'h0, ext = 16'h0;
    logic [15:0] pin, pad_in, pad_out, pad_oe;
    logic [63:0] fdat = 64'h0, fdrv = 64'h0;
    int          fail_count = 0, tests_run = 0;

    spio_port #(.IMPL_MASK(IMPL)) u_spio_port (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_enable(pen), .periph_driving(pdrv), .periph_data(pdat),
        .periph_in(pin), .func_data(fdat), .func_driving(fdrv),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    spio_far_model u_spio_far_model (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pad_in(pad_in));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        if (n >= 64) begin
            fail_count++;
            stop_test();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        if (n >= 64) begin
            fail_count++;
            stop_test();
        end
    endtask : rd

    task automatic setp(input logic [15:0] e, input logic [15:0] dr, input logic [15:0] da);
        @(posedge ref_clk);
        pen <= e;
        pdrv <= dr;
        pdat <= da;
    endtask : setp

    // Pad outputs are combinational, so they are looked at mid-cycle.
    task automatic pins(input logic [15:0] eo, input logic [15:0] ed, input logic [15:0] m);
        @(negedge ref_clk);
        chk({16'h0, pad_oe & m}, {16'h0, eo & m});
        chk({16'h0, pad_out & m}, {16'h0, ed & m});
    endtask : pins

    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`SPIO_OFF_DIRECTION, {16'h0, IMPL}, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_LATCH, 32'h0, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_SELECT_4, 32'h0, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_SELECT_5, 32'h0, `SPIO_RESP_OKAY);
        rd(8'h14, 32'h0, `SPIO_RESP_SLVERR);
        wr(8'h14, 32'hFFFF, `SPIO_RESP_SLVERR);
        wr(`SPIO_OFF_DIRECTION, 32'h0, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_LATCH, 32'hFFFF, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_LATCH, {16'h0, IMPL}, `SPIO_RESP_OKAY);
        pins(IMPL, IMPL, 16'hFFFF);
        wr(`SPIO_OFF_PIN_LEVEL, 32'h00A5, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_LATCH, 32'h00A5, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_PIN_LEVEL, 32'h00A5, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_LATCH, 32'h0040, `SPIO_RESP_OKAY);
        setp(16'h00A0, 16'h0000, 16'h0020);
        pins(IMPL, 16'h0040, IMPL);
        chk({16'h0, pin & 16'h0040}, 32'h0);
        // Bit 15 is missing on this variant: its driving peripheral must stay off the pad.
        setp(16'h80A0, 16'h8020, 16'h8020);
        pins(IMPL, 16'h0060, IMPL);
        rd(`SPIO_OFF_PIN_LEVEL, 32'h0060, `SPIO_RESP_OKAY);
        setp(16'h0000, 16'h0000, 16'h0000);
        ext <= 16'h9234;
        wr(`SPIO_OFF_DIRECTION, 32'hFFFF, `SPIO_RESP_OKAY);
        // With the drivers off the latch still stands on the data lines.
        pins(16'h0000, 16'h0040, 16'hFFFF);
        rd(`SPIO_OFF_PIN_LEVEL, 32'h1234, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_SELECT_4, 32'hFFFF, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_SELECT_4, 32'h3F3F, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_SELECT_5, 32'hFFFF, `SPIO_RESP_OKAY);
        rd(`SPIO_OFF_SELECT_5, 32'h3F3F, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_DIRECTION, 32'h0, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_LATCH, 32'h0, `SPIO_RESP_OKAY);
        wr(`SPIO_OFF_SELECT_4, 32'h0305, `SPIO_RESP_OKAY);
        // Function 0 drives high too, so a selector of zero that connects it shows.
        fdat <= 64'h21;
        fdrv <= 64'h21;
        pins(16'h0003, 16'h0001, 16'h0003);
        wr(`SPIO_OFF_SELECT_4, 32'h0, `SPIO_RESP_OKAY);
        pins(16'h0003, 16'h0000, 16'h0003);
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
